// ### rtl/dprb_bank.sv
/*
  DSP port register bank: decode of the fourteen DSP locations, the
  wide-band, sample, transmit, DAC and control registers, mailbox queue
  access and the interrupt control/status bits.
  Assumes a synchronous DSP port: strobes are one-cycle pulses on clk_in,
  read data is returned on the edge after the read strobe, and the queue
  head word is valid whenever a read of the queue location is made.
*/
`timescale 1ns/1ps
module dprb_bank (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // DSP register port.
  input wire logic [3:0] dsp_addr_in,
  input wire logic [9:0] dsp_wdata_in,
  input wire logic dsp_wr_in,
  input wire logic dsp_rd_in,
  output logic [9:0] dsp_rdata_out,
  // Wide-band demodulator side.
  input wire logic wideband_bit_in,
  input wire logic wideband_bit_valid_in,
  input wire logic wideband_locked_in,
  input wire logic wideband_irq_event_in,
  output logic wideband_enable_out,
  output logic [2:0] wideband_bandwidth_out,
  output logic wideband_irq_out,
  // Receive converter samples.
  input wire logic [9:0] rx_inphase_in,
  input wire logic [9:0] rx_quadrature_in,
  input wire logic rx_sample_valid_in,
  // Mailbox queues.
  input wire logic [9:0] mbox_head_in,
  output logic mbox_pop_out,
  output logic mbox_push_out,
  output logic [9:0] mbox_push_word_out,
  // Interrupts exchanged with the microcontroller side.
  input wire logic mc_send_c_in,
  input wire logic mc_clear_d_in,
  input wire logic mc_clear_f_in,
  output logic irq_c_out,
  output logic irq_d_out,
  output logic irq_f_out,
  // Symbol interrupt.
  input wire logic symbol_interrupt_in,
  output logic symbol_irq_out,
  // Transmit data paths.
  output logic [9:0] tx_dac_inphase_out,
  output logic [9:0] tx_dac_quadrature_out,
  output logic [9:0] modulator_data_out,
  output logic [1:0] burst_offset_code_out,
  // Timing and control DACs.
  output logic [9:0] symbol_timing_adjust_out,
  output logic [9:0] gain_dac_out,
  output logic [9:0] frequency_dac_out,
  output logic [9:0] power_dac_out,
  // Mode and power controls.
  output logic transmit_go_out,
  output logic mode_digital_out,
  output logic speech_codec_enable_out,
  output logic fm_voice_enable_out,
  output logic q_input_fm_select_out,
  output logic fm_receiver_enable_out,
  output logic quad_receiver_enable_out,
  output logic quad_side_enable_out,
  output logic transmitter_power_enable_out,
  output logic general_output_out,
  output logic receive_offset_measure_out,
  output logic analog_loopback_out,
  output logic rx_pins_connect_out
);

  typedef struct packed {
    logic [7:0] wb_data;
    logic wb_enable;
    logic [2:0] wb_bw;
    logic [9:0] rx_i;
    logic [9:0] rx_q;
    logic [9:0] tx_i;
    logic [9:0] tx_q;
    logic sym_disable;
    logic [9:0] timing_adj;
    logic [9:0] agc;
    logic [9:0] afc;
    logic [9:0] pwr;
    logic [9:0] misc;
    logic [1:0] burst;
    logic [9:0] rdata;
    logic push;
    logic [9:0] push_word;
  } dprb_bank_s;

  dprb_bank_s state;
  dprb_bank_s next_state;

  logic wr_irq;
  logic clr_wb;
  logic clr_c;
  logic send_d;
  logic send_f;
  logic pend_wb;
  logic pend_c;
  logic pend_d;
  logic pend_f;
  logic [9:0] irq_read;
  logic [9:0] wbc_read;

  // Writes to interrupt control act on the clear and send bits only when written as one.
  // zero has no effect there; the symbol disable takes the written bit
  assign wr_irq = dsp_wr_in && (dsp_addr_in == dprb_pkg::ADDR_INTERRUPT_CONTROL);
  assign clr_wb = wr_irq && dsp_wdata_in[dprb_pkg::IRQ_CLEAR_WB];
  assign clr_c = wr_irq && dsp_wdata_in[dprb_pkg::IRQ_CLEAR_C];
  assign send_d = wr_irq && dsp_wdata_in[dprb_pkg::IRQ_SEND_D];
  assign send_f = wr_irq && dsp_wdata_in[dprb_pkg::IRQ_SEND_F];

  // Wide-band interrupt toward the DSP.
  dprb_irq_flag u_flag_wb (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(wideband_irq_event_in),
    .clear_in(clr_wb),
    .pending_out(pend_wb)
  );

  // Interrupt C, raised by the microcontroller side toward the DSP.
  dprb_irq_flag u_flag_c (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(mc_send_c_in),
    .clear_in(clr_c),
    .pending_out(pend_c)
  );

  // Interrupt D, raised by the DSP toward the microcontroller.
  dprb_irq_flag u_flag_d (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(send_d),
    .clear_in(mc_clear_d_in),
    .pending_out(pend_d)
  );

  // Interrupt F, raised by the DSP toward the microcontroller.
  dprb_irq_flag u_flag_f (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(send_f),
    .clear_in(mc_clear_f_in),
    .pending_out(pend_f)
  );

  // Symbol interrupt gate toward the DSP.
  // disable gates symbol interrupt
  dprb_symbol_gate u_symbol_gate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .symbol_raw_in(symbol_interrupt_in),
    .disable_in(state.sym_disable),
    .symbol_irq_out(symbol_irq_out)
  );

  // Read images of the two mixed registers; unlisted bits stay zero.
  // pending reads as one
  always_comb begin
    irq_read = dprb_pkg::WORD_RST;
    irq_read[dprb_pkg::IRQ_CLEAR_WB] = pend_wb;
    irq_read[dprb_pkg::IRQ_SYM_DISABLE] = state.sym_disable;
    irq_read[dprb_pkg::IRQ_CLEAR_C] = pend_c;
    irq_read[dprb_pkg::IRQ_SEND_D] = pend_d;
    irq_read[dprb_pkg::IRQ_SEND_F] = pend_f;
    wbc_read = dprb_pkg::WORD_RST;
    wbc_read[dprb_pkg::WBC_LOCKED] = wideband_locked_in;
    wbc_read[dprb_pkg::WBC_ENABLE] = state.wb_enable;
    wbc_read[dprb_pkg::WBC_BW_LSB +: dprb_pkg::WBC_BW_W] = state.wb_bw;
  end

  // Next-state logic for the whole bank.
  always_comb begin
    next_state = state;
    next_state.push = 1'h0;
    // newest bit enters at wb_data bit 7, read back as bit 9
    if (wideband_bit_valid_in) begin
      next_state.wb_data = {wideband_bit_in, state.wb_data[dprb_pkg::WB_DATA_W-1:1]};
    end
    if (rx_sample_valid_in) begin
      next_state.rx_i = rx_inphase_in;
      next_state.rx_q = rx_quadrature_in;
    end
    if (dsp_wr_in) begin
      case (dsp_addr_in)
        dprb_pkg::ADDR_WIDEBAND_CONTROL: begin
          next_state.wb_enable = dsp_wdata_in[dprb_pkg::WBC_ENABLE];
          next_state.wb_bw = dsp_wdata_in[dprb_pkg::WBC_BW_LSB +: dprb_pkg::WBC_BW_W];
        end
        dprb_pkg::ADDR_TX_INPHASE_DATA: begin
          next_state.tx_i = dsp_wdata_in;
        end
        dprb_pkg::ADDR_TX_QUADRATURE_DATA: begin
          next_state.tx_q = dsp_wdata_in;
        end
        dprb_pkg::ADDR_MAILBOX_QUEUE_PORT: begin
          next_state.push = 1'h1;
          next_state.push_word = dsp_wdata_in;
        end
        dprb_pkg::ADDR_INTERRUPT_CONTROL: begin
          next_state.sym_disable = dsp_wdata_in[dprb_pkg::IRQ_SYM_DISABLE];
        end
        dprb_pkg::ADDR_SYMBOL_TIMING_ADJUST: begin
          next_state.timing_adj = dsp_wdata_in;
        end
        dprb_pkg::ADDR_GAIN_CONTROL_DAC: begin
          next_state.agc = dsp_wdata_in;
        end
        dprb_pkg::ADDR_FREQUENCY_CONTROL_DAC: begin
          next_state.afc = dsp_wdata_in;
        end
        dprb_pkg::ADDR_POWER_CONTROL_DAC: begin
          next_state.pwr = dsp_wdata_in;
        end
        dprb_pkg::ADDR_MISC_STATUS_CONTROL: begin
          next_state.misc = dsp_wdata_in;
        end
        dprb_pkg::ADDR_BURST_OFFSET: begin
          next_state.burst = dsp_wdata_in[dprb_pkg::BURST_W-1:0];
        end
        default: begin
          next_state.push = 1'h0;
        end
      endcase
    end
    if (dsp_rd_in) begin
      case (dsp_addr_in)
        dprb_pkg::ADDR_WIDEBAND_DATA: begin
          next_state.rdata = {state.wb_data, 2'h0};
        end
        dprb_pkg::ADDR_WIDEBAND_CONTROL: begin
          next_state.rdata = wbc_read;
        end
        dprb_pkg::ADDR_RX_INPHASE_SAMPLE: begin
          next_state.rdata = state.rx_i;
        end
        dprb_pkg::ADDR_RX_QUADRATURE_SAMPLE: begin
          next_state.rdata = state.rx_q;
        end
        dprb_pkg::ADDR_MAILBOX_QUEUE_PORT: begin
          next_state.rdata = mbox_head_in;
        end
        dprb_pkg::ADDR_INTERRUPT_CONTROL: begin
          next_state.rdata = irq_read;
        end
        dprb_pkg::ADDR_MISC_STATUS_CONTROL: begin
          next_state.rdata = state.misc & dprb_pkg::MSC_READ_MASK;
        end
        default: begin
          // Write-only and unmapped locations read as zero.
          next_state.rdata = dprb_pkg::WORD_RST;
        end
      endcase
    end
  end

  // State register; the symbol disable resets to one and the wide-band bandwidth to 6.
  // disable set at reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.sym_disable <= dprb_pkg::SYM_DISABLE_RST;
      state.wb_enable <= dprb_pkg::WB_ENABLE_RST;
      state.wb_bw <= dprb_pkg::WB_BW_RST;
      state.misc <= dprb_pkg::MSC_RST;
    end else begin
      state <= next_state;
    end
  end

  // Register port and queue outputs.
  assign dsp_rdata_out = state.rdata;
  assign mbox_pop_out = dsp_rd_in && (dsp_addr_in == dprb_pkg::ADDR_MAILBOX_QUEUE_PORT);
  assign mbox_push_out = state.push;
  assign mbox_push_word_out = state.push_word;

  // Interrupt pins follow the pending flags.
  assign wideband_irq_out = pend_wb;
  assign irq_c_out = pend_c;
  assign irq_d_out = pend_d;
  assign irq_f_out = pend_f;

  // Wide-band module controls.
  assign wideband_enable_out = state.wb_enable;
  assign wideband_bandwidth_out = state.wb_bw;

  // Transmit routing depends on mode; unused paths are held at zero so
  // a stale word is never driven into a converter that is not in use.
  // analog feeds DACs
  assign tx_dac_inphase_out = mode_digital_out ? dprb_pkg::WORD_RST : state.tx_i;
  assign tx_dac_quadrature_out = mode_digital_out ? dprb_pkg::WORD_RST : state.tx_q;
  assign modulator_data_out = mode_digital_out ? state.tx_i : dprb_pkg::WORD_RST;
  assign burst_offset_code_out = state.burst;

  // Timing adjust and DAC words.
  assign symbol_timing_adjust_out = state.timing_adj;
  assign gain_dac_out = state.agc;
  assign frequency_dac_out = state.afc;
  assign power_dac_out = state.pwr;

  // Mode and burst control.
  // mode select
  assign mode_digital_out = state.misc[dprb_pkg::MSC_MODE];
  // burst follows transmit-go in digital mode
  assign transmit_go_out = state.misc[dprb_pkg::MSC_TRANSMIT_GO] && mode_digital_out;

  // Power and routing controls.
  // codec clocks
  assign speech_codec_enable_out = state.misc[dprb_pkg::MSC_SPEECH_CODEC];
  assign fm_voice_enable_out = state.misc[dprb_pkg::MSC_FM_VOICE];
  assign q_input_fm_select_out = state.misc[dprb_pkg::MSC_FM_VOICE];
  assign fm_receiver_enable_out = state.misc[dprb_pkg::MSC_FM_RECEIVER];
  assign quad_receiver_enable_out = state.misc[dprb_pkg::MSC_QUAD_RECEIVER];
  // quadrature side also enabled by FM voice
  assign quad_side_enable_out = state.misc[dprb_pkg::MSC_QUAD_RECEIVER] ||
    state.misc[dprb_pkg::MSC_FM_VOICE];
  assign transmitter_power_enable_out = state.misc[dprb_pkg::MSC_TX_POWER];
  assign general_output_out = state.misc[dprb_pkg::MSC_GENERAL_OUT];
  assign receive_offset_measure_out = state.misc[dprb_pkg::MSC_RX_OFFSET];
  assign analog_loopback_out = state.misc[dprb_pkg::MSC_LOOPBACK];
  // pins disconnected in offset or loopback
  assign rx_pins_connect_out = !(state.misc[dprb_pkg::MSC_RX_OFFSET] ||
    state.misc[dprb_pkg::MSC_LOOPBACK]);

endmodule : dprb_bank

// ### rtl/dprb_irq_flag.sv
/*
  One pending-interrupt flag: set by an event, cleared by a request.
  Assumes set and clear are one-cycle pulses synchronous to clk_in.
*/
`timescale 1ns/1ps
module dprb_irq_flag (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Set and clear requests.
  input wire logic set_in,
  input wire logic clear_in,
  // Pending level.
  output logic pending_out
);

  typedef struct packed {
    logic pending;
  } dprb_flag_s;

  dprb_flag_s state;
  dprb_flag_s next_state;

  // A set arriving with a clear wins, so no event is ever lost.
  always_comb begin
    next_state = state;
    if (clear_in) begin
      next_state.pending = 1'h0;
    end
    if (set_in) begin
      next_state.pending = 1'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pending_out = state.pending;

endmodule : dprb_irq_flag

// ### rtl/dprb_pkg.sv
/*
  Shared constants of the DSP port register bank: register addresses,
  field positions, widths and reset values.
  Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
*/
package dprb_pkg;

  // Port geometry.
  localparam int DATA_W = 10;
  localparam int ADDR_W = 4;

  // Register addresses on the DSP port.
  localparam logic [3:0] ADDR_WIDEBAND_DATA = 4'h0;
  localparam logic [3:0] ADDR_WIDEBAND_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_RX_INPHASE_SAMPLE = 4'h2;
  localparam logic [3:0] ADDR_RX_QUADRATURE_SAMPLE = 4'h3;
  localparam logic [3:0] ADDR_TX_INPHASE_DATA = 4'h4;
  localparam logic [3:0] ADDR_TX_QUADRATURE_DATA = 4'h5;
  localparam logic [3:0] ADDR_MAILBOX_QUEUE_PORT = 4'h6;
  localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_SYMBOL_TIMING_ADJUST = 4'h8;
  localparam logic [3:0] ADDR_GAIN_CONTROL_DAC = 4'h9;
  localparam logic [3:0] ADDR_FREQUENCY_CONTROL_DAC = 4'hA;
  localparam logic [3:0] ADDR_POWER_CONTROL_DAC = 4'hB;
  localparam logic [3:0] ADDR_MISC_STATUS_CONTROL = 4'hC;
  localparam logic [3:0] ADDR_BURST_OFFSET = 4'hD;

  // Wide-band data: received bits sit in 9..2, newest at the top.
  localparam int WB_DATA_LSB = 2;
  localparam int WB_DATA_W = 8;

  // Wide-band control fields.
  localparam int WBC_LOCKED = 9;
  localparam int WBC_ENABLE = 8;
  localparam int WBC_BW_LSB = 5;
  localparam int WBC_BW_W = 3;
  localparam logic WB_ENABLE_RST = 1'h0;
  localparam logic [2:0] WB_BW_RST = 3'h6;

  // Interrupt control fields.
  localparam int IRQ_CLEAR_WB = 9;
  localparam int IRQ_SYM_DISABLE = 8;
  localparam int IRQ_CLEAR_C = 7;
  localparam int IRQ_SEND_D = 6;
  localparam int IRQ_SEND_F = 5;
  localparam logic SYM_DISABLE_RST = 1'h1;

  // Miscellaneous status/control fields.
  localparam int MSC_TRANSMIT_GO = 9;
  localparam int MSC_MODE = 8;
  localparam int MSC_SPEECH_CODEC = 7;
  localparam int MSC_FM_VOICE = 6;
  localparam int MSC_FM_RECEIVER = 5;
  localparam int MSC_QUAD_RECEIVER = 4;
  localparam int MSC_TX_POWER = 3;
  localparam int MSC_GENERAL_OUT = 2;
  localparam int MSC_RX_OFFSET = 1;
  localparam int MSC_LOOPBACK = 0;
  localparam logic [9:0] MSC_RST = 10'h000;
  // Bits that read back; the general output is write-only.
  localparam logic [9:0] MSC_READ_MASK = 10'h3FB;

  // Burst offset field and the quarter-period divisor of the delay.
  localparam int BURST_W = 2;
  localparam int BURST_QUARTERS = 4;

  // Common reset value of data registers.
  localparam logic [9:0] WORD_RST = 10'h000;

endpackage : dprb_pkg

// ### rtl/dprb_symbol_gate.sv
/*
  Gate for the symbol interrupt toward the DSP.
  Assumes the raw symbol interrupt is a level synchronous to clk_in.
*/
`timescale 1ns/1ps
module dprb_symbol_gate (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw symbol interrupt and the disable control.
  input wire logic symbol_raw_in,
  input wire logic disable_in,
  // Gated symbol interrupt.
  output logic symbol_irq_out
);

  typedef struct packed {
    logic gate_open;
    logic irq;
  } dprb_gate_s;

  dprb_gate_s state;
  dprb_gate_s next_state;

  // The gate moves only while the raw line is low, so a pulse is passed
  // whole or not at all and is never cut short.
  always_comb begin
    next_state = state;
    if (!symbol_raw_in) begin
      next_state.gate_open = !disable_in;
    end
    next_state.irq = symbol_raw_in && next_state.gate_open;
  end

  // State register; the gate starts closed as the disable starts set.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign symbol_irq_out = state.irq;

endmodule : dprb_symbol_gate

// ### testbench/dprb_bank_chk.sv
/*
  Concurrent checks on the DSP port register bank.
  Assumes it is bound to dprb_bank and sees only that module's ports.
*/
`timescale 1ns/1ps
module dprb_bank_chk (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port.
  input wire logic [3:0] dsp_addr_in,
  input wire logic [9:0] dsp_wdata_in,
  input wire logic dsp_wr_in,
  input wire logic dsp_rd_in,
  input wire logic [9:0] dsp_rdata_out,
  // Mailbox queues.
  input wire logic [9:0] mbox_head_in,
  input wire logic mbox_pop_out,
  input wire logic mbox_push_out,
  input wire logic [9:0] mbox_push_word_out,
  // Interrupts.
  input wire logic mc_send_c_in,
  input wire logic irq_c_out,
  input wire logic irq_d_out,
  input wire logic symbol_interrupt_in,
  input wire logic symbol_irq_out,
  // Transmit controls.
  input wire logic transmit_go_out,
  input wire logic mode_digital_out,
  input wire logic [9:0] tx_dac_quadrature_out,
  input wire logic [1:0] burst_offset_code_out
);
  // All checks share the one clock, so reset disables them all at once.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_POP: assert property (mbox_pop_out == (dsp_rd_in && dsp_addr_in == 4'h6))
    else $error("queue pop strobe wrong");
  AST_QREAD: assert property (dsp_rd_in && dsp_addr_in == 4'h6
    |=> dsp_rdata_out == $past(mbox_head_in)) else $error("queue read data wrong");
  AST_PUSH: assert property (dsp_wr_in && dsp_addr_in == 4'h6
    |=> mbox_push_out && mbox_push_word_out == $past(dsp_wdata_in))
    else $error("queue push wrong");
  AST_CLR_C: assert property (dsp_wr_in && dsp_addr_in == 4'h7
    && dsp_wdata_in[7] && !mc_send_c_in |=> !irq_c_out) else $error("clear C failed");
  AST_SEND_D: assert property (dsp_wr_in && dsp_addr_in == 4'h7
    && dsp_wdata_in[6] |=> irq_d_out) else $error("send D failed");
  // A pulse already passing the gate must run to its natural end.
  AST_SYM_HOLD: assert property (symbol_irq_out && symbol_interrupt_in
    |=> symbol_irq_out) else $error("symbol pulse shortened");
  AST_SYM_SRC: assert property (symbol_irq_out |-> $past(symbol_interrupt_in))
    else $error("symbol output without source");
  AST_TRANSMIT_GO: assert property (dsp_wr_in && dsp_addr_in == 4'hC
    |=> transmit_go_out == ($past(dsp_wdata_in[9]) && $past(dsp_wdata_in[8])))
    else $error("transmit go wrong");
  AST_TXQ: assert property (mode_digital_out |-> tx_dac_quadrature_out == 10'h000)
    else $error("quadrature DAC fed in digital mode");
  AST_BURST: assert property (dsp_wr_in && dsp_addr_in == 4'hD
    |=> burst_offset_code_out == $past(dsp_wdata_in[1:0])) else $error("burst code wrong");
endmodule : dprb_bank_chk

bind dprb_bank dprb_bank_chk chk (.*);

// ### testbench/dprb_dsp_model.sv
/*
  Behavioural model of the DSP driving the register port.
  Assumes one clock and one-cycle strobes, read data one edge later.
*/
`timescale 1ns/1ps
module dprb_dsp_model (
  // Clock.
  input wire logic clk_in,
  // Register port toward the bank.
  output logic [3:0] dsp_addr_out,
  output logic [9:0] dsp_wdata_out,
  output logic dsp_wr_out,
  output logic dsp_rd_out,
  input wire logic [9:0] dsp_rdata_in
);
  // Idle port: strobes low, address parked on an unmapped location.
  initial begin
    dsp_addr_out = 4'hF;
    dsp_wdata_out = 10'h000;
    dsp_wr_out = 1'b0;
    dsp_rd_out = 1'b0;
  end

  // One access, then an idle cycle so no signal is set twice in one step.
  task automatic access(input logic wr, input logic [3:0] a, input logic [9:0] d,
                        output logic [9:0] q);
    dsp_addr_out = a;
    dsp_wdata_out = d;
    dsp_wr_out = wr;
    dsp_rd_out = !wr;
    @(posedge clk_in);
    #1;
    dsp_wr_out = 1'b0;
    dsp_rd_out = 1'b0;
    dsp_addr_out = ~a;
    dsp_wdata_out = ~d;
    q = dsp_rdata_in;
    @(posedge clk_in);
    #1;
  endtask : access
endmodule : dprb_dsp_model

// ### testbench/dsp_port_register_bank_test.sv
/*
  Self-checking bench for the DSP port register bank.
  Assumes dprb_bank, its checker and the DSP model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module dsp_port_register_bank_test;
  logic clk_in, rst_n_in, dsp_wr_in, dsp_rd_in, wideband_bit_in, wideband_bit_valid_in;
  logic wideband_locked_in, wideband_irq_event_in, wideband_enable_out, wideband_irq_out;
  logic [3:0] dsp_addr_in;
  logic [2:0] wideband_bandwidth_out;
  logic [1:0] burst_offset_code_out;
  logic [9:0] dsp_wdata_in, dsp_rdata_out, rx_inphase_in, rx_quadrature_in, mbox_head_in;
  logic [9:0] mbox_push_word_out, tx_dac_inphase_out, tx_dac_quadrature_out;
  logic [9:0] modulator_data_out, symbol_timing_adjust_out, gain_dac_out;
  logic [9:0] frequency_dac_out, power_dac_out;
  logic rx_sample_valid_in, mbox_pop_out, mbox_push_out, mc_send_c_in, mc_clear_d_in;
  logic mc_clear_f_in, irq_c_out, irq_d_out, irq_f_out, symbol_interrupt_in, symbol_irq_out;
  logic transmit_go_out, mode_digital_out, speech_codec_enable_out, fm_voice_enable_out;
  logic q_input_fm_select_out, fm_receiver_enable_out, quad_receiver_enable_out;
  logic quad_side_enable_out, transmitter_power_enable_out, general_output_out;
  logic receive_offset_measure_out, analog_loopback_out, rx_pins_connect_out;
  int fails = 0;
  int n_tests = 0;
  logic [9:0] p, e;
  // Rows: address, write data, expected read back; read-only, write-only, unmapped and the wide-band control.
  logic [23:0] rows [12] = '{{4'h0, 10'h3FF, 10'h000}, {4'h1, 10'h3FF, 10'h1E0},
    {4'h2, 10'h3FF, 10'h000}, {4'h4, 10'h155, 10'h000}, {4'h5, 10'h2AA, 10'h000},
    {4'h8, 10'h3FF, 10'h000}, {4'h9, 10'h3FF, 10'h000}, {4'hA, 10'h3FF, 10'h000},
    {4'hB, 10'h3FF, 10'h000}, {4'hD, 10'h3FF, 10'h000}, {4'hE, 10'h3FF, 10'h000},
    {4'hF, 10'h3FF, 10'h000}};
  logic [9:0] pats [3] = '{10'h3FF, 10'h155, 10'h2AA};
  // Control bits of location 12 gathered in register order.
  wire [9:0] misc = {transmit_go_out, mode_digital_out, speech_codec_enable_out,
    fm_voice_enable_out, fm_receiver_enable_out, quad_receiver_enable_out,
    transmitter_power_enable_out, general_output_out, receive_offset_measure_out,
    analog_loopback_out};

  dprb_bank DUT (.*);
  dprb_dsp_model dsp (.clk_in(clk_in), .dsp_addr_out(dsp_addr_in),
    .dsp_wdata_out(dsp_wdata_in), .dsp_wr_out(dsp_wr_in), .dsp_rd_out(dsp_rd_in),
    .dsp_rdata_in(dsp_rdata_out));

  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Bus helpers; stimulus always moves 1 ns after a rising edge.
  task automatic w(input logic [3:0] a, input logic [9:0] d);
    logic [9:0] q;
    dsp.access(1'b1, a, d, q);
  endtask : w
  task automatic rc(input string s, input logic [3:0] a, input logic [9:0] x);
    logic [9:0] q;
    dsp.access(1'b0, a, 10'h000, q);
    `CHK(s, x, q)
  endtask : rc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_in);
    #1;
    s = 1'b0;
  endtask : pulse
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  // Free-running 50 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Watchdog: a hang counts as a mismatch and still reaches the verdict.
  initial begin
    #1900000;
    fails++;
    close_out();
  end

  initial begin
    rst_n_in = 1'b0;
    {wideband_bit_in, wideband_bit_valid_in, wideband_locked_in, wideband_irq_event_in} = 4'h0;
    {rx_sample_valid_in, mc_send_c_in, mc_clear_d_in, mc_clear_f_in} = 4'h0;
    symbol_interrupt_in = 1'b0;
    rx_inphase_in = 10'h1A5;
    rx_quadrature_in = 10'h25A;
    mbox_head_in = 10'h2A5;
    cyc(2);
    rst_n_in = 1'b1;
    rc("irq reset", 4'h7, 10'h100);
    rc("wbc reset", 4'h1, 10'h0C0);
    `CHK("pins reset", 1'b1, rx_pins_connect_out)
    foreach (rows[i]) begin
      w(rows[i][23:20], rows[i][19:10]);
      rc("row", rows[i][23:20], rows[i][9:0]);
    end
    `CHK("wb ctl", 4'hF, {wideband_enable_out, wideband_bandwidth_out})
    `CHK("dacs", {4{10'h3FF}}, {symbol_timing_adjust_out, gain_dac_out, frequency_dac_out, power_dac_out})
    `CHK("analog path", {10'h155, 10'h2AA, 10'h000}, {tx_dac_inphase_out, tx_dac_quadrature_out, modulator_data_out})
    $display("register map done");
    foreach (pats[i]) begin
      p = pats[i];
      e = p;
      e[9] = p[9] & p[8];
      w(4'hC, p);
      `CHK("misc bits", e, misc)
      `CHK("quad side", p[4] | p[6], quad_side_enable_out)
      `CHK("fm select", p[6], q_input_fm_select_out)
      `CHK("pins", !(p[1] | p[0]), rx_pins_connect_out)
      rc("misc read", 4'hC, p & 10'h3FB);
    end
    // Burst on then off in digital mode.
    w(4'hC, 10'h300);
    `CHK("digital path", {10'h155, 10'h000, 1'b1}, {modulator_data_out, tx_dac_inphase_out, transmit_go_out})
    w(4'hC, 10'h100);
    `CHK("burst end", 1'b0, transmit_go_out)
    w(4'hC, 10'h000);
    for (int d = 0; d < 4; d++) begin
      w(4'hD, 10'(d));
      `CHK("burst code", 2'(d), burst_offset_code_out)
    end
    $display("controls done");
    // Bit 8 is written on every access here, so keep the symbol disable set.
    w(4'h7, 10'h160);
    rc("send", 4'h7, 10'h160);
    w(4'h7, 10'h100);
    rc("zero write", 4'h7, 10'h160);
    pulse(mc_clear_d_in);
    pulse(mc_send_c_in);
    rc("c pending", 4'h7, 10'h1A0);
    w(4'h7, 10'h180);
    `CHK("clear c", 1'b0, irq_c_out)
    pulse(wideband_irq_event_in);
    rc("wb pending", 4'h7, 10'h320);
    w(4'h7, 10'h300);
    rc("wb cleared", 4'h7, 10'h120);
    pulse(mc_clear_f_in);
    `CHK("f cleared", 3'h0, {wideband_irq_out, irq_d_out, irq_f_out})
    $display("interrupts done");
    symbol_interrupt_in = 1'b1;
    cyc(3);
    `CHK("sym blocked", 1'b0, symbol_irq_out)
    symbol_interrupt_in = 1'b0;
    w(4'h7, 10'h000);
    symbol_interrupt_in = 1'b1;
    cyc(2);
    `CHK("sym passes", 1'b1, symbol_irq_out)
    w(4'h7, 10'h100);
    `CHK("sym kept", 1'b1, symbol_irq_out)
    symbol_interrupt_in = 1'b0;
    cyc(2);
    symbol_interrupt_in = 1'b1;
    cyc(2);
    `CHK("sym stopped", 1'b0, symbol_irq_out)
    symbol_interrupt_in = 1'b0;
    $display("symbol gate done");
    rc("queue read", 4'h6, 10'h2A5);
    w(4'h6, 10'h1C3);
    `CHK("queue word", 10'h1C3, mbox_push_word_out)
    for (int i = 0; i < 8; i++) begin
      wideband_bit_in = 1'(8'hB2 >> i);
      pulse(wideband_bit_valid_in);
      // Let an edge pass so the valid strobe is not set twice in one step.
      cyc(1);
    end
    rc("wb data", 4'h0, 10'h2C8);
    wideband_locked_in = 1'b1;
    rc("wb locked", 4'h1, 10'h3E0);
    pulse(rx_sample_valid_in);
    rc("rx i", 4'h2, 10'h1A5);
    rc("rx q", 4'h3, 10'h25A);
    $display("data paths done");
    rst_n_in = 1'b0;
    cyc(1);
    rst_n_in = 1'b1;
    rc("irq rereset", 4'h7, 10'h100);
    $display("second reset done");
    close_out();
  end
endmodule : dsp_port_register_bank_test
